// *** oel_enable_reg.sv ***
/*
  One edge enable register with write, set and clear addresses.
  Assumes the parent hands it a one-cycle write strobe and the raw address; the address decode is done here.
*/
`timescale 1ns/10ps
module oel_enable_reg
  import oel_pkg::*;
#(
  parameter int          WIDTH      = 5,
  parameter logic [7:0]  WR_ADDR    = 8'h10,
  parameter logic [7:0]  SET_ADDR   = 8'h11,
  parameter logic [7:0]  CLR_ADDR   = 8'h12,
  parameter logic [4:0]  RESET_VAL  = 5'h1f
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_addr,
  input  wire logic [7:0]       wr_data,
  output logic      [WIDTH-1:0] enable_ff
);

  // ***********************************************************
  // write, set and clear decode
  // ***********************************************************
  oel_op_t          op;
  logic [WIDTH-1:0] nxt_enable;

  always_comb begin
    op = OEL_OP_NONE;
    if (wr_en) begin
      if (wr_addr == WR_ADDR) begin
        op = OEL_OP_WRITE;
      end else if (wr_addr == SET_ADDR) begin
        op = OEL_OP_SET;
      end else if (wr_addr == CLR_ADDR) begin
        op = OEL_OP_CLEAR;
      end
    end
  end

  always_comb begin
    case (op)
      OEL_OP_WRITE: nxt_enable = wr_data[WIDTH-1:0];
      OEL_OP_SET:   nxt_enable = enable_ff | wr_data[WIDTH-1:0];
      OEL_OP_CLEAR: nxt_enable = enable_ff & ~wr_data[WIDTH-1:0];
      default:      nxt_enable = enable_ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_ff <= RESET_VAL[WIDTH-1:0];
    end else begin
      enable_ff <= nxt_enable;
    end
  end

endmodule

// *** oel_event_latch.sv ***
/*
  Event detection registers of the transceiver: rising and falling edge
  enables, live source status, clear-on-read event latch and line state
  debug view.
  Assumes the register port is driven synchronously to clk by the link
  side, one access per cycle, and that detector inputs are already
  synchronous to clk.
*/
`timescale 1ns/10ps
module oel_event_latch
  import oel_pkg::*;
#(
  parameter int NUM_SRC = OEL_NUM_SRC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               reg_wr_en,
  input  wire logic               reg_rd_en,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wr_data,
  output logic      [7:0]         reg_rd_data,
  output logic                    reg_rd_hit,
  input  wire logic               id_grounded,
  input  wire logic               session_over,
  input  wire logic               session_ok,
  input  wire logic               bus_voltage_ok,
  input  wire logic               host_unplug,
  input  wire logic               line_level_bit0,
  input  wire logic               line_level_bit1,
  input  wire logic               low_power_enter,
  output logic      [NUM_SRC-1:0] event_pulse,
  output logic      [NUM_SRC-1:0] event_latch
);

  // ***********************************************************
  // source vector
  // ***********************************************************
  logic [NUM_SRC-1:0] src_now;
  logic [NUM_SRC-1:0] src_prev_ff;
  logic [NUM_SRC-1:0] rise_en;
  logic [NUM_SRC-1:0] fall_en;
  logic [NUM_SRC-1:0] event_hit;
  logic [NUM_SRC-1:0] latch_ff;
  logic [NUM_SRC-1:0] nxt_latch;
  logic [NUM_SRC-1:0] pulse_ff;
  logic [7:0]         rd_data_ff;
  logic               rd_hit_ff;
  logic [7:0]         nxt_rd_data;
  logic               nxt_rd_hit;
  logic               latch_read;

  always_comb begin
    src_now                       = '0;
    src_now[OEL_BIT_ID_GROUNDED]  = id_grounded;
    src_now[OEL_BIT_SESSION_OVER] = session_over;
    src_now[OEL_BIT_SESSION_OK]   = session_ok;
    src_now[OEL_BIT_BUS_VOLT_OK]  = bus_voltage_ok;
    src_now[OEL_BIT_HOST_UNPLUG]  = host_unplug;
  end

  // ***********************************************************
  // enable registers
  // ***********************************************************
  oel_enable_reg #(
    .WIDTH     (NUM_SRC),
    .WR_ADDR   (OEL_RISE_WR_ADDR),
    .SET_ADDR  (OEL_RISE_SET_ADDR),
    .CLR_ADDR  (OEL_RISE_CLR_ADDR),
    .RESET_VAL (OEL_RISE_RESET)
  ) u_rise_en (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (reg_wr_en),
    .wr_addr   (reg_addr),
    .wr_data   (reg_wr_data),
    .enable_ff (rise_en)
  );

  oel_enable_reg #(
    .WIDTH     (NUM_SRC),
    .WR_ADDR   (OEL_FALL_WR_ADDR),
    .SET_ADDR  (OEL_FALL_SET_ADDR),
    .CLR_ADDR  (OEL_FALL_CLR_ADDR),
    .RESET_VAL (OEL_FALL_RESET)
  ) u_fall_en (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (reg_wr_en),
    .wr_addr   (reg_addr),
    .wr_data   (reg_wr_data),
    .enable_ff (fall_en)
  );

  // ***********************************************************
  // edge detection
  // ***********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      src_prev_ff <= '0;
    end else begin
      src_prev_ff <= src_now;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_edge
      // falling edges per source
      // rising edges per source
      assign event_hit[gi] =
        (fall_en[gi] & src_prev_ff[gi] & ~src_now[gi]) |
        (rise_en[gi] & ~src_prev_ff[gi] & src_now[gi]);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_ff <= '0;
    end else begin
      pulse_ff <= event_hit;
    end
  end

  // ***********************************************************
  // event latch
  // ***********************************************************
  assign latch_read = reg_rd_en & (reg_addr == OEL_LATCH_ADDR);

  always_comb begin
    nxt_latch = latch_ff;
    if (latch_read || low_power_enter) begin
      nxt_latch = '0;
    end
    nxt_latch = nxt_latch | event_hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_ff <= OEL_LATCH_RESET;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // ***********************************************************
  // read port
  // ***********************************************************
  always_comb begin
    nxt_rd_data = 8'h00;
    nxt_rd_hit  = 1'b0;
    if (reg_rd_en) begin
      nxt_rd_hit = 1'b1;
      case (reg_addr)
        OEL_RISE_WR_ADDR, OEL_RISE_SET_ADDR, OEL_RISE_CLR_ADDR:
          nxt_rd_data[NUM_SRC-1:0] = rise_en;
        OEL_FALL_WR_ADDR, OEL_FALL_SET_ADDR, OEL_FALL_CLR_ADDR:
          nxt_rd_data[NUM_SRC-1:0] = fall_en;
        OEL_STATUS_ADDR:
          nxt_rd_data[NUM_SRC-1:0] = src_now;
        OEL_LATCH_ADDR:
          nxt_rd_data[NUM_SRC-1:0] = latch_ff;
        OEL_DEBUG_ADDR: begin
          nxt_rd_data[OEL_BIT_LINE_LEVEL1] = line_level_bit1;
          nxt_rd_data[OEL_BIT_LINE_LEVEL0] = line_level_bit0;
        end
        default: nxt_rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
      rd_hit_ff  <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_hit_ff  <= nxt_rd_hit;
    end
  end

  assign reg_rd_data = rd_data_ff;
  assign reg_rd_hit  = rd_hit_ff;
  assign event_pulse = pulse_ff;
  assign event_latch = latch_ff;

endmodule

// *** oel_event_latch_tb.sv ***
/* self-checking bench of the event latch registers
   assumes oel_link_model and the bound checker are compiled */
`timescale 1ns/10ps
module oel_event_latch_tb
  import oel_pkg::*;
;
  logic       clk, rst, wr_en, rd_en, hit, lp;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] src;
  logic [1:0] line;
  int         num_errors = 0;
  int         checks_done = 0;
  oel_event_latch dut (.clk(clk), .rst(rst), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata),
    .reg_rd_data(rdata), .reg_rd_hit(hit), .id_grounded(src[4]),
    .session_over(src[3]), .session_ok(src[2]), .bus_voltage_ok(src[1]),
    .host_unplug(src[0]), .line_level_bit0(line[0]),
    .line_level_bit1(line[1]), .low_power_enter(lp), .event_pulse(),
    .event_latch());
  oel_link_model link (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata),
    .reg_rd_hit(hit));
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic eh);
    logic [7:0] d;
    logic       h;
    link.rd(a, d, h);
    chk($sformatf("data at %h", a), e, d);
    chk($sformatf("hit at %h", a), {7'h00, eh}, {7'h00, h});
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  // ***********************************************************
  // register scenarios
  // ***********************************************************
  initial begin
    rst = 1'b1;
    src = 5'h00;
    line = 2'h0;
    lp = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h0d; a <= 8'h12; a++) rdc(8'(a), 8'h1f, 1'b1);
    rdc(OEL_LATCH_ADDR, 8'h00, 1'b1);
    rdc(OEL_DEBUG_ADDR, 8'h00, 1'b1);
    rdc(8'h16, 8'h00, 1'b0);
    rdc(8'h0c, 8'h00, 1'b0);
    link.wr(OEL_FALL_WR_ADDR, 8'he5);
    rdc(OEL_FALL_CLR_ADDR, 8'h05, 1'b1);
    link.wr(OEL_FALL_SET_ADDR, 8'h0a);
    rdc(OEL_FALL_WR_ADDR, 8'h0f, 1'b1);
    link.wr(OEL_FALL_CLR_ADDR, 8'h03);
    rdc(OEL_FALL_SET_ADDR, 8'h0c, 1'b1);
    link.wr(OEL_RISE_WR_ADDR, 8'hf0);
    link.wr(OEL_RISE_SET_ADDR, 8'h01);
    rdc(OEL_RISE_CLR_ADDR, 8'h11, 1'b1);
    link.wr(OEL_RISE_CLR_ADDR, 8'hff);
    rdc(OEL_RISE_SET_ADDR, 8'h00, 1'b1);
    link.wr(OEL_STATUS_ADDR, 8'hff);
    rdc(OEL_STATUS_ADDR, 8'h00, 1'b1);
    @(posedge clk) src <= 5'h1f;
    line <= 2'h2;
    rdc(OEL_STATUS_ADDR, 8'h1f, 1'b1);
    rdc(OEL_DEBUG_ADDR, 8'h02, 1'b1);
    rdc(OEL_LATCH_ADDR, 8'h00, 1'b1);
    @(posedge clk) line <= 2'h1;
    rdc(OEL_DEBUG_ADDR, 8'h01, 1'b1);
    for (int i = 0; i < 5; i++) begin
      link.wr(OEL_FALL_WR_ADDR, 8'h01 << i);
      @(posedge clk) src <= 5'h1f;
      rdc(OEL_LATCH_ADDR, 8'h00, 1'b1);
      @(posedge clk) src <= 5'h00;
      rdc(OEL_LATCH_ADDR, 8'h01 << i, 1'b1);
      rdc(OEL_LATCH_ADDR, 8'h00, 1'b1);
    end
    link.wr(OEL_RISE_WR_ADDR, 8'h1f);
    @(posedge clk) src <= 5'h15;
    rdc(OEL_LATCH_ADDR, 8'h15, 1'b1);
    @(posedge clk) src <= 5'h05;
    @(posedge clk) lp <= 1'b1;
    @(posedge clk) lp <= 1'b0;
    rdc(OEL_LATCH_ADDR, 8'h00, 1'b1);
    // edge arrives in the very cycle of the latch read strobe
    fork
      rdc(OEL_LATCH_ADDR, 8'h00, 1'b1);
      @(posedge clk) src <= 5'h15;
    join
    rdc(OEL_LATCH_ADDR, 8'h10, 1'b1);
    tally_and_finish();
  end
endmodule

// *** oel_link_model.sv ***
/* link side register access model
   assumes the block answers a read one cycle after the strobe */
`timescale 1ns/10ps
module oel_link_model (
  input  wire logic       clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wr_data,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_hit
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  // write, set or clear by offset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wr_data <= ~d;
  endtask
  // latch reads happen only when the caller asks
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic h);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    // answer stands for the cycle after the strobe edge; take it mid cycle
    @(negedge clk);
    d = reg_rd_data;
    h = reg_rd_hit;
  endtask
endmodule

// *** oel_pkg.sv ***
/*
  Package for the event latch register block: register offsets, field
  positions, reset values and command encodings.
  Assumes a single 200 MHz clock domain shared by every user.
*/
package oel_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OEL_RISE_WR_ADDR  = 8'h0d;
  localparam logic [7:0] OEL_RISE_SET_ADDR = 8'h0e;
  localparam logic [7:0] OEL_RISE_CLR_ADDR = 8'h0f;
  localparam logic [7:0] OEL_FALL_WR_ADDR  = 8'h10;
  localparam logic [7:0] OEL_FALL_SET_ADDR = 8'h11;
  localparam logic [7:0] OEL_FALL_CLR_ADDR = 8'h12;
  localparam logic [7:0] OEL_STATUS_ADDR   = 8'h13;
  localparam logic [7:0] OEL_LATCH_ADDR    = 8'h14;
  localparam logic [7:0] OEL_DEBUG_ADDR    = 8'h15;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int OEL_NUM_SRC          = 5;
  localparam int OEL_BIT_HOST_UNPLUG  = 0;
  localparam int OEL_BIT_BUS_VOLT_OK  = 1;
  localparam int OEL_BIT_SESSION_OK   = 2;
  localparam int OEL_BIT_SESSION_OVER = 3;
  localparam int OEL_BIT_ID_GROUNDED  = 4;
  localparam int OEL_BIT_LINE_LEVEL0  = 0;
  localparam int OEL_BIT_LINE_LEVEL1  = 1;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [4:0] OEL_RISE_RESET  = 5'h1f;
  localparam logic [4:0] OEL_FALL_RESET  = 5'h1f;
  localparam logic [4:0] OEL_LATCH_RESET = 5'h00;

  // ***********************************************************
  // register access commands
  // ***********************************************************
  typedef enum logic [1:0] {
    OEL_OP_NONE  = 2'h0,
    OEL_OP_WRITE = 2'h1,
    OEL_OP_SET   = 2'h2,
    OEL_OP_CLEAR = 2'h3
  } oel_op_t;

endpackage

// *** oel_props.sv ***
/* assertions on the event latch block ports
   assumes one clock domain, bound to every oel_event_latch */
`timescale 1ns/10ps
module oel_props
  import oel_pkg::*;
#(
  parameter int NUM_SRC = OEL_NUM_SRC
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               reg_rd_en,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_rd_data,
  input wire logic               reg_rd_hit,
  input wire logic               id_grounded,
  input wire logic               session_over,
  input wire logic               session_ok,
  input wire logic               bus_voltage_ok,
  input wire logic               host_unplug,
  input wire logic               line_level_bit0,
  input wire logic               line_level_bit1,
  input wire logic               low_power_enter,
  input wire logic [NUM_SRC-1:0] event_pulse,
  input wire logic [NUM_SRC-1:0] event_latch
);
  logic [4:0] src;
  assign src = {id_grounded, session_over, session_ok, bus_voltage_ok,
                host_unplug};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_at(logic [7:0] a);
    reg_rd_en && reg_addr == a;
  endsequence
  sequence latch_ans;
    reg_rd_hit && reg_rd_data == {3'h0, $past(event_latch)};
  endsequence
  status_live_a: assert property (rd_at(OEL_STATUS_ADDR) |=>
    reg_rd_hit && reg_rd_data == {3'h0, $past(src)}) else $error("status");
  debug_live_a: assert property (rd_at(OEL_DEBUG_ADDR) |=>
    reg_rd_hit && reg_rd_data == {6'h00, $past(line_level_bit1),
    $past(line_level_bit0)}) else $error("debug");
  unmapped_rd_a: assert property (reg_rd_en && (reg_addr < 8'h0d ||
    reg_addr > 8'h15) |=> !reg_rd_hit && reg_rd_data == 8'h00)
    else $error("unmapped read");
  idle_zero_a: assert property (!reg_rd_en |=> !reg_rd_hit &&
    reg_rd_data == 8'h00) else $error("idle read data");
  latch_read_a: assert property (rd_at(OEL_LATCH_ADDR) |=> latch_ans)
    else $error("latch read");
  latch_clr_a: assert property (rd_at(OEL_LATCH_ADDR) |=>
    event_latch == event_pulse) else $error("latch read clear");
  low_pwr_clr_a: assert property (low_power_enter |=>
    event_latch == event_pulse) else $error("low power clear");
  latch_hold_a: assert property (!(reg_rd_en &&
    reg_addr == OEL_LATCH_ADDR) && !low_power_enter |=>
    event_latch == ($past(event_latch) | event_pulse)) else $error("hold");
  pulse_cause_a: assert property (event_pulse != '0 && !$past(rst, 2) |->
    (event_pulse & ~($past(src) ^ $past(src, 2))) == '0)
    else $error("pulse without edge");
endmodule
bind oel_event_latch oel_props #(.NUM_SRC(NUM_SRC)) u_props (.clk(clk),
  .rst(rst), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit),
  .id_grounded(id_grounded), .session_over(session_over),
  .session_ok(session_ok), .bus_voltage_ok(bus_voltage_ok),
  .host_unplug(host_unplug), .line_level_bit0(line_level_bit0),
  .line_level_bit1(line_level_bit1), .low_power_enter(low_power_enter),
  .event_pulse(event_pulse), .event_latch(event_latch));
